// [rtl/gpfm_defines.vh]
`ifndef GPFM_DEFINES_VH
`define GPFM_DEFINES_VH
// Summary of operation
// [RULE1] Pin 12: gpio, priority, serial rx, debug rx
// [RULE2] Pin 11: gpio, request, serial tx, debug tx
// [RULE3] Pin 10: narrowband wake output in wake mode
// [RULE4] Pin 9 lan wake out, pin 8 in
// [RULE5] Pin 7: gpio, narrowband lamp, lan reset
// [RULE6] Pin 6 audio receive data input
// [RULE7] Pin 5 audio transmit data output
// [RULE8] Pin 4 bit clock, direction by role
// [RULE9] Pin 3 codec clock or lan lamp
// [RULE10] Pin 2 frame sync, direction by role
// [RULE11] Low energy sync on pin 2 or 29
// [RULE12] Pin 1 resets narrowband subsystem only
// [RULE13] Pin 0 oscillator enable, boot high, tristate down; the code applies i_pdn_oe[0] in down after firmware
// [RULE14] Pins 1-12 inputs, programmable down state, pulls
// [RULE15] Front-end lines low in reset, boot, down; the code drives i_fe_pdn_val in down after firmware
// [RULE16] Wake sideband active low, input, no pulls; the code drives it low when functional and i_link_wake_n is low
// [RULE17] Clock request sideband drives low after reset
// [RULE18] Link reset input shares pin 31, pull-down
// [RULE19] Post-boot state holds until firmware download
// [RULE20] Pulls act only while pad is input
// [RULE21] One selector per pin, default plain input
// [RULE22] Power-down applies programmed per-pad state

// Function selector codes
`define GPFM_SEL_GPIO    3'h0
`define GPFM_SEL_ALT1    3'h1
`define GPFM_SEL_ALT2    3'h2
`define GPFM_SEL_ALT3    3'h3
// Field widths
`define GPFM_SEL_W       3
`define GPFM_NPINS       13
`define GPFM_NFE         16
// Reset values
`define GPFM_PULLUP_RST  13'h1_FFE
`define GPFM_FE_RST      16'h0000
`endif

// [rtl/gpfm_pad_cell.v]
`timescale 1ns/10ps
// Single pad with pull gating and power-down override
module gpfm_pad_cell (
	// Functional side
	input  wire i_fn_oe,
	input  wire i_fn_out,
	input  wire i_pu_en,
	input  wire i_pd_en,
	// Power-down side
	input  wire i_pdn,
	input  wire i_pdn_oe,
	input  wire i_pdn_val,
	// Pad side
	output wire o_oe,
	output wire o_out,
	output wire o_pu,
	output wire o_pd
);
	// Power-down state replaces functional state
	assign o_oe  = i_pdn ? i_pdn_oe  : i_fn_oe;  // see [RULE22]
	assign o_out = i_pdn ? i_pdn_val : i_fn_out;
	// Pulls only when the pad is an input
	assign o_pu  = i_pu_en & ~o_oe;              // see [RULE20]
	assign o_pd  = i_pd_en & ~o_oe;
endmodule

// [rtl/gpfm_boot_phase.v]
`timescale 1ns/10ps
`include "gpfm_defines.vh"
// Tracks reset, post-boot and functional phases
module gpfm_boot_phase (
	// Clock and reset
	input  wire i_sys_clk,
	input  wire i_rst_n,
	// Phase events
	input  wire i_boot_done,
	input  wire i_fw_dl_start,
	// Phase flags
	output reg  o_post_boot,
	output reg  o_functional
);
	localparam ST_RESET = 3'b001;
	localparam ST_BOOT  = 3'b010;
	localparam ST_FUNC  = 3'b100;
	reg [2:0] state_reg;
	reg [2:0] state_next;

	// Phase sequencing
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET: begin
				if (i_boot_done)
					state_next = ST_BOOT;
			end
			ST_BOOT: begin
				if (i_fw_dl_start)
					state_next = ST_FUNC;  // see [RULE19]
			end
			ST_FUNC: state_next = ST_FUNC;
			default: state_next = ST_RESET;
		endcase
	end

	// State and flags
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg    <= ST_RESET;
			o_post_boot  <= 1'b0;
			o_functional <= 1'b0;
		end else begin
			state_reg    <= state_next;
			o_post_boot  <= (state_next == ST_BOOT);
			o_functional <= (state_next == ST_FUNC);
		end
	end
endmodule

// [rtl/gpfm_pin_mux.v]
`timescale 1ns/10ps
`include "gpfm_defines.vh"
// ****************************************
// Pin function multiplexer top
// ****************************************
module gpfm_pin_mux #(
	parameter NPINS = `GPFM_NPINS,
	parameter NFE   = `GPFM_NFE
) (
	// Clock and reset
	input  wire                 i_sys_clk,
	input  wire                 i_rst_n,
	// Phase control
	input  wire                 i_boot_done,
	input  wire                 i_fw_dl_start,
	input  wire                 i_power_down_state,
	// Configuration
	input  wire [NPINS*3-1:0]   i_func_sel,
	input  wire                 i_audio_central,
	input  wire                 i_le_sync_on_29,
	input  wire [NPINS-1:0]     i_pu_en,
	input  wire [NPINS-1:0]     i_pd_en,
	input  wire [NPINS-1:0]     i_pdn_oe,
	input  wire [NPINS-1:0]     i_pdn_val,
	input  wire [NFE-1:0]       i_fe_pdn_val,
	// Plain pin control
	input  wire [NPINS-1:0]     i_gpio_oe,
	input  wire [NPINS-1:0]     i_gpio_out,
	// Internal function sources
	input  wire                 i_coex_serial_tx,
	input  wire                 i_debug_serial_tx,
	input  wire                 i_narrowband_wake_to_host,
	input  wire                 i_lan_wake_to_host,
	input  wire                 i_narrowband_activity_lamp,
	input  wire                 i_lan_activity_lamp,
	input  wire                 i_audio_tx_data,
	input  wire                 i_audio_bit_clk,
	input  wire                 i_audio_frame_sync,
	input  wire                 i_stereo_codec_clock,
	input  wire                 i_ext_oscillator_enable,
	input  wire [NFE-1:0]       i_front_end_ctrl_line,
	input  wire                 i_link_wake_n,
	input  wire                 i_link_clock_request_n,
	// Pad inputs
	input  wire [NPINS-1:0]     i_pad_in,
	input  wire                 i_pad29_in,
	input  wire                 i_link_reset_n_pad,
	input  wire                 i_link_wake_n_pad,
	input  wire                 i_link_clock_request_n_pad,
	// Pad outputs
	output reg  [NPINS-1:0]     o_pad_oe,
	output reg  [NPINS-1:0]     o_pad_out,
	output reg  [NPINS-1:0]     o_pad_pu,
	output reg  [NPINS-1:0]     o_pad_pd,
	output reg  [NFE-1:0]       o_fe_oe,
	output reg  [NFE-1:0]       o_fe_out,
	output reg                  o_link_wake_n_oe,
	output reg                  o_link_wake_n_out,
	output reg                  o_link_clock_request_n_oe,
	output reg                  o_link_clock_request_n_out,
	output reg                  o_link_reset_pd,
	// Decoded inputs to functions
	output reg                  o_coex_priority_in,
	output reg                  o_coex_request_in,
	output reg                  o_coex_serial_rx,
	output reg                  o_debug_serial_rx,
	output reg                  o_lan_wake_request_in,
	output reg                  o_lan_subsystem_reset_in,
	output reg                  o_narrowband_subsystem_reset_in,
	output reg                  o_audio_rx_data,
	output reg                  o_audio_bit_clk_in,
	output reg                  o_audio_frame_sync_in,
	output reg                  o_low_energy_audio_sync,
	output reg                  o_link_reset_n,
	output reg                  o_link_wake_n_in,
	output reg                  o_link_clock_request_n_in,
	output reg  [NPINS-1:0]     o_gpio_in
);
	// ****************************************
	// Selector decode
	// ****************************************
	function [2:0] sel_of;
		input [NPINS*3-1:0] vec;
		input integer       idx;
		begin
			sel_of = vec[idx*3 +: 3];
		end
	endfunction

	wire post_boot;
	wire functional;
	reg  [NPINS-1:0] fn_oe;
	reg  [NPINS-1:0] fn_out;
	reg  [NPINS-1:0] alt_active;
	wire [NPINS-1:0] cell_oe;
	wire [NPINS-1:0] cell_out;
	wire [NPINS-1:0] cell_pu;
	wire [NPINS-1:0] cell_pd;
	reg  [NPINS-1:0] pdn_oe_eff;
	reg  [NPINS-1:0] pdn_val_eff;
	reg  [NPINS*3-1:0] sel_eff;
	integer k;

	gpfm_boot_phase u_phase (
		.i_sys_clk     (i_sys_clk),
		.i_rst_n       (i_rst_n),
		.i_boot_done   (i_boot_done),
		.i_fw_dl_start (i_fw_dl_start),
		.o_post_boot   (post_boot),
		.o_functional  (functional)
	);

	// Per-pin function steering
	always @* begin
		fn_oe      = {NPINS{1'b0}};
		fn_out     = {NPINS{1'b0}};
		alt_active = {NPINS{1'b0}};
		if (functional) begin
			for (k = 0; k < NPINS; k = k + 1) begin
				fn_oe[k]      = i_gpio_oe[k];
				fn_out[k]     = i_gpio_out[k];
				alt_active[k] = (sel_of(i_func_sel, k) != `GPFM_SEL_GPIO);  // see [RULE21]
			end
			// Pin 12 alternates are all inputs
			if (alt_active[12])
				fn_oe[12] = 1'b0;  // see [RULE1]
			// Pin 11 request input or serial outputs
			case (sel_of(i_func_sel, 11))
				`GPFM_SEL_ALT1: fn_oe[11] = 1'b0;  // see [RULE2]
				`GPFM_SEL_ALT2: begin
					fn_oe[11]  = 1'b1;
					fn_out[11] = i_coex_serial_tx;
				end
				`GPFM_SEL_ALT3: begin
					fn_oe[11]  = 1'b1;
					fn_out[11] = i_debug_serial_tx;
				end
				default: ;
			endcase
			if (alt_active[10]) begin
				fn_oe[10]  = 1'b1;
				fn_out[10] = i_narrowband_wake_to_host;  // see [RULE3]
			end
			if (alt_active[9]) begin
				fn_oe[9]  = 1'b1;
				fn_out[9] = i_lan_wake_to_host;  // see [RULE4]
			end
			if (alt_active[8])
				fn_oe[8] = 1'b0;  // see [RULE4]
			case (sel_of(i_func_sel, 7))
				`GPFM_SEL_ALT1: begin
					fn_oe[7]  = 1'b1;
					fn_out[7] = i_narrowband_activity_lamp;  // see [RULE5]
				end
				`GPFM_SEL_ALT2: fn_oe[7] = 1'b0;
				default: ;
			endcase
			if (alt_active[6])
				fn_oe[6] = 1'b0;  // see [RULE6]
			if (alt_active[5]) begin
				fn_oe[5]  = 1'b1;
				fn_out[5] = i_audio_tx_data;  // see [RULE7]
			end
			// Bit clock driven only when device is central
			if (alt_active[4]) begin
				fn_oe[4]  = i_audio_central;  // see [RULE8]
				fn_out[4] = i_audio_bit_clk;
			end
			case (sel_of(i_func_sel, 3))
				`GPFM_SEL_ALT1: begin
					fn_oe[3]  = 1'b1;
					fn_out[3] = i_stereo_codec_clock;  // see [RULE9]
				end
				`GPFM_SEL_ALT2: begin
					fn_oe[3]  = 1'b1;
					fn_out[3] = i_lan_activity_lamp;
				end
				default: ;
			endcase
			case (sel_of(i_func_sel, 2))
				`GPFM_SEL_ALT1: begin
					fn_oe[2]  = i_audio_central;  // see [RULE10]
					fn_out[2] = i_audio_frame_sync;
				end
				`GPFM_SEL_ALT2: fn_oe[2] = 1'b0;  // see [RULE11]
				default: ;
			endcase
			if (alt_active[1])
				fn_oe[1] = 1'b0;  // see [RULE12]
			if (alt_active[0]) begin
				fn_oe[0]  = 1'b1;
				fn_out[0] = i_ext_oscillator_enable;  // see [RULE13]
			end
		end else begin
			// Reset and post-boot: pin 0 drives, others input
			fn_oe[0]  = 1'b1;  // see [RULE14]
			fn_out[0] = post_boot;  // see [RULE13]
		end
	end

	// Power-down values and selectors, defaults apply before firmware
	always @* begin
		pdn_oe_eff  = functional ? i_pdn_oe  : {NPINS{1'b0}};  // see [RULE14]
		pdn_val_eff = functional ? i_pdn_val : {NPINS{1'b0}};
		// Decoded inputs stay idle until firmware owns the pins
		sel_eff     = functional ? i_func_sel : {(NPINS*3){1'b0}};  // see [RULE21]
	end

	genvar g;
	generate
		for (g = 0; g < NPINS; g = g + 1) begin : g_pad
			gpfm_pad_cell u_cell (
				.i_fn_oe   (fn_oe[g]),
				.i_fn_out  (fn_out[g]),
				.i_pu_en   (functional ? i_pu_en[g] : 1'b1),
				.i_pd_en   (functional ? i_pd_en[g] : 1'b0),
				.i_pdn     (i_power_down_state),
				.i_pdn_oe  (pdn_oe_eff[g]),
				.i_pdn_val (pdn_val_eff[g]),
				.o_oe      (cell_oe[g]),
				.o_out     (cell_out[g]),
				.o_pu      (cell_pu[g]),
				.o_pd      (cell_pd[g])
			);
		end
	endgenerate

	// ****************************************
	// Registered pad and function outputs
	// ****************************************
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pad_oe                   <= 13'h0001;
			o_pad_out                  <= 13'h0000;
			o_pad_pu                   <= `GPFM_PULLUP_RST;
			o_pad_pd                   <= 13'h0000;
			o_fe_oe                    <= {NFE{1'b1}};
			o_fe_out                   <= `GPFM_FE_RST;
			o_link_wake_n_oe           <= 1'b0;
			o_link_wake_n_out          <= 1'b1;
			o_link_clock_request_n_oe  <= 1'b1;
			o_link_clock_request_n_out <= 1'b0;
			o_link_reset_pd            <= 1'b1;
			o_coex_priority_in         <= 1'b0;
			o_coex_request_in          <= 1'b0;
			o_coex_serial_rx           <= 1'b1;
			o_debug_serial_rx          <= 1'b1;
			o_lan_wake_request_in      <= 1'b0;
			o_lan_subsystem_reset_in   <= 1'b0;
			o_narrowband_subsystem_reset_in <= 1'b0;
			o_audio_rx_data            <= 1'b0;
			o_audio_bit_clk_in         <= 1'b0;
			o_audio_frame_sync_in      <= 1'b0;
			o_low_energy_audio_sync    <= 1'b0;
			o_link_reset_n             <= 1'b0;
			o_link_wake_n_in           <= 1'b1;
			o_link_clock_request_n_in  <= 1'b1;
			o_gpio_in                  <= 13'h0000;
		end else begin
			o_pad_oe  <= cell_oe;
			o_pad_out <= cell_out;
			o_pad_pu  <= cell_pu;
			o_pad_pd  <= cell_pd;
			// Front-end lines low until firmware, programmed value in down
			o_fe_oe   <= {NFE{1'b1}};  // see [RULE15]
			if (!functional)
				o_fe_out <= `GPFM_FE_RST;
			else if (i_power_down_state)
				o_fe_out <= i_fe_pdn_val;
			else
				o_fe_out <= i_front_end_ctrl_line;
			// Sidebands: link reset pull-down only; wake input and clock request low until firmware, then each driven low on request
			o_link_wake_n_oe  <= functional & ~i_link_wake_n;  // see [RULE16]
			o_link_wake_n_out <= 1'b0;
			o_link_clock_request_n_oe  <= ~functional | ~i_link_clock_request_n;  // see [RULE17]
			o_link_clock_request_n_out <= 1'b0;
			o_link_reset_pd <= 1'b1;  // see [RULE18]
			o_link_reset_n  <= i_link_reset_n_pad;
			o_link_wake_n_in          <= i_link_wake_n_pad;
			o_link_clock_request_n_in <= i_link_clock_request_n_pad;
			o_gpio_in <= i_pad_in;
			// Decoded inputs, idle when function not selected
			o_coex_priority_in <= (sel_of(sel_eff, 12) == `GPFM_SEL_ALT1) & i_pad_in[12];
			o_coex_serial_rx   <= (sel_of(sel_eff, 12) == `GPFM_SEL_ALT2) ? i_pad_in[12] : 1'b1;
			o_debug_serial_rx  <= (sel_of(sel_eff, 12) == `GPFM_SEL_ALT3) ? i_pad_in[12] : 1'b1;
			o_coex_request_in  <= (sel_of(sel_eff, 11) == `GPFM_SEL_ALT1) & i_pad_in[11];
			o_lan_wake_request_in <= alt_active[8] & i_pad_in[8];  // see [RULE4]
			o_lan_subsystem_reset_in <= (sel_of(sel_eff, 7) == `GPFM_SEL_ALT2) & i_pad_in[7];
			o_narrowband_subsystem_reset_in <= alt_active[1] & i_pad_in[1];  // see [RULE12]
			o_audio_rx_data       <= alt_active[6] & i_pad_in[6];
			o_audio_bit_clk_in    <= alt_active[4] & ~i_audio_central & i_pad_in[4];
			o_audio_frame_sync_in <= (sel_of(sel_eff, 2) == `GPFM_SEL_ALT1)
				& ~i_audio_central & i_pad_in[2];
			// Only one of pin 2 or pin 29 serves the sync
			if (i_le_sync_on_29)
				o_low_energy_audio_sync <= functional & i_pad29_in;  // see [RULE11]
			else
				o_low_energy_audio_sync <= (sel_of(sel_eff, 2) == `GPFM_SEL_ALT2) & i_pad_in[2];
		end
	end
endmodule

// [testbench/gpfm_pin_mux_assertions.sv]
`timescale 1ns/10ps
// ****************************************
// Pad mux checker
// ****************************************
module gpfm_pin_mux_chk #(
	parameter NPINS = 13,
	parameter NFE   = 16
) (
	input wire               i_sys_clk, i_rst_n, i_boot_done, i_fw_dl_start, i_power_down_state,
	input wire               i_audio_central, i_audio_tx_data, i_link_reset_n_pad,
	input wire [NPINS*3-1:0] i_func_sel,
	input wire [NPINS-1:0]   o_pad_oe, o_pad_out, o_pad_pu, o_pad_pd,
	input wire [NFE-1:0]     o_fe_oe, o_fe_out,
	input wire               o_link_wake_n_oe, o_link_clock_request_n_oe,
	input wire               o_link_clock_request_n_out, o_link_reset_n, o_link_reset_pd
);
	reg boot_seen, fw_seen, fw_d1, fw_d2;
	// Phase tracking
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			boot_seen <= 1'b0;
			fw_seen <= 1'b0;
			fw_d1 <= 1'b0;
			fw_d2 <= 1'b0;
		end else begin
			boot_seen <= boot_seen | i_boot_done;
			fw_seen <= fw_seen | i_fw_dl_start;
			fw_d1 <= fw_seen;
			fw_d2 <= fw_d1;
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// Early phase pad states
	a_fe_held_low: assert property (!fw_seen |-> &o_fe_oe && o_fe_out == 0)
		else $error("front-end lines not low");
	a_side_idle: assert property (!fw_seen |-> o_link_clock_request_n_oe &&
		!o_link_clock_request_n_out && !o_link_wake_n_oe) else $error("sideband state wrong");
	a_pins_input: assert property (!fw_seen |-> o_pad_oe[NPINS-1:1] == 0 &&
		&o_pad_pu[NPINS-1:1]) else $error("pins not pulled inputs");
	a_osc_low: assert property (!boot_seen |-> o_pad_oe[0] && !o_pad_out[0])
		else $error("oscillator pin not low");
	a_osc_high: assert property (boot_seen && $past(boot_seen) && !fw_seen
		|-> o_pad_oe[0] && o_pad_out[0]) else $error("oscillator pin not high");
	// Pads and sidebands at any time
	a_pull_gate: assert property ((o_pad_oe & (o_pad_pu | o_pad_pd)) == 0)
		else $error("pull active on driven pad");
	a_link_reset: assert property ($past(i_rst_n) |-> o_link_reset_pd &&
		o_link_reset_n == $past(i_link_reset_n_pad)) else $error("link reset path wrong");
	// Audio pins in functional phase
	a_bclk_dir: assert property (fw_d2 && $past(i_func_sel[14:12]) != 0 &&
		!$past(i_power_down_state) |-> o_pad_oe[4] == $past(i_audio_central))
		else $error("bit clock direction wrong");
	a_tx_data: assert property (fw_d2 && $past(i_func_sel[17:15]) != 0 &&
		!$past(i_power_down_state) |-> o_pad_oe[5] && o_pad_out[5] == $past(i_audio_tx_data))
		else $error("transmit data pin wrong");
	c_func: cover property ($rose(fw_d2));
	c_periph: cover property (fw_d2 && !o_pad_oe[4]);
	c_pdn: cover property (fw_d2 && i_power_down_state);
endmodule
bind gpfm_pin_mux gpfm_pin_mux_chk #(.NPINS(NPINS), .NFE(NFE)) u_chk (.i_sys_clk, .i_rst_n,
	.i_boot_done, .i_fw_dl_start, .i_power_down_state, .i_audio_central, .i_audio_tx_data,
	.i_link_reset_n_pad, .i_func_sel, .o_pad_oe, .o_pad_out, .o_pad_pu, .o_pad_pd, .o_fe_oe,
	.o_fe_out, .o_link_wake_n_oe, .o_link_clock_request_n_oe, .o_link_clock_request_n_out,
	.o_link_reset_n, .o_link_reset_pd);

// [testbench/gpfm_pad_world.sv]
`timescale 1ns/10ps
// ****************************************
// Pads, pulls and external drivers
// ****************************************
module gpfm_pad_world #(
	parameter N = 13
) (
	input  wire         i_sys_clk,
	input  wire [N-1:0] i_oe, i_out, i_pu, i_pd, i_ext_en, i_ext_val,
	output wire [N-1:0] o_level
);
	reg [N-1:0] last_reg = 0;
	// Pad drive, then codec or radio drive, then pulls, else inverse of last
	assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val) |
		(~i_oe & ~i_ext_en & (i_pu | (~i_pd & ~last_reg)));
	// Remember last level for floating pads
	always @(posedge i_sys_clk) begin
		last_reg <= o_level;
	end
endmodule

// [testbench/gpfm_pin_mux_tb.sv]
`timescale 1ns/10ps
// ****************************************
// Pad mux bench
// ****************************************
module gpfm_pin_mux_tb;
	reg         i_sys_clk = 0, i_rst_n = 0, i_boot_done = 0, i_fw_dl_start = 0;
	reg         i_power_down_state = 0, i_audio_central = 0, i_le_sync_on_29 = 0;
	reg  [38:0] i_func_sel = 0;
	reg  [12:0] i_pu_en = 13'h1fff, i_pd_en = 0, i_pdn_oe = 0, i_pdn_val = 0;
	reg  [12:0] i_gpio_oe = 0, i_gpio_out = 0, ext_en = 0, ext_val = 0;
	reg  [15:0] i_fe_pdn_val = 0, i_front_end_ctrl_line = 0;
	reg         i_coex_serial_tx = 0, i_debug_serial_tx = 0, i_narrowband_wake_to_host = 0;
	reg         i_lan_wake_to_host = 0, i_narrowband_activity_lamp = 0, i_lan_activity_lamp = 0;
	reg         i_audio_tx_data = 0, i_audio_bit_clk = 0, i_audio_frame_sync = 0;
	reg         i_stereo_codec_clock = 0, i_ext_oscillator_enable = 0, i_link_wake_n = 1;
	reg         i_link_clock_request_n = 1, i_pad29_in = 1, i_link_reset_n_pad = 1, host_wake_n = 1;
	wire [12:0] i_pad_in, o_pad_oe, o_pad_out, o_pad_pu, o_pad_pd, o_gpio_in;
	wire [15:0] o_fe_oe, o_fe_out;
	wire        o_link_wake_n_oe, o_link_wake_n_out, o_link_clock_request_n_oe;
	wire        o_link_clock_request_n_out, o_link_reset_pd, o_coex_priority_in, o_coex_request_in;
	wire        o_coex_serial_rx, o_debug_serial_rx, o_lan_wake_request_in, o_audio_rx_data;
	wire        o_lan_subsystem_reset_in, o_narrowband_subsystem_reset_in, o_audio_bit_clk_in;
	wire        o_audio_frame_sync_in, o_low_energy_audio_sync, o_link_reset_n, o_link_wake_n_in;
	wire        o_link_clock_request_n_in, i_link_wake_n_pad, i_link_clock_request_n_pad;
	integer     err_count = 0, cmp_count = 0, c;
	// Open-drain sidebands with host pull-ups
	assign i_link_wake_n_pad = o_link_wake_n_oe ? o_link_wake_n_out : host_wake_n;
	assign i_link_clock_request_n_pad = o_link_clock_request_n_oe ? o_link_clock_request_n_out : 1'b1;
	gpfm_pin_mux dut (.i_sys_clk, .i_rst_n, .i_boot_done, .i_fw_dl_start, .i_power_down_state,
		.i_func_sel, .i_audio_central, .i_le_sync_on_29, .i_pu_en, .i_pd_en, .i_pdn_oe, .i_pdn_val,
		.i_fe_pdn_val, .i_gpio_oe, .i_gpio_out, .i_coex_serial_tx, .i_debug_serial_tx,
		.i_narrowband_wake_to_host, .i_lan_wake_to_host, .i_narrowband_activity_lamp,
		.i_lan_activity_lamp, .i_audio_tx_data, .i_audio_bit_clk, .i_audio_frame_sync,
		.i_stereo_codec_clock, .i_ext_oscillator_enable, .i_front_end_ctrl_line, .i_link_wake_n,
		.i_link_clock_request_n, .i_pad_in, .i_pad29_in, .i_link_reset_n_pad, .i_link_wake_n_pad,
		.i_link_clock_request_n_pad, .o_pad_oe, .o_pad_out, .o_pad_pu, .o_pad_pd, .o_fe_oe,
		.o_fe_out, .o_link_wake_n_oe, .o_link_wake_n_out, .o_link_clock_request_n_oe,
		.o_link_clock_request_n_out, .o_link_reset_pd, .o_coex_priority_in, .o_coex_request_in,
		.o_coex_serial_rx, .o_debug_serial_rx, .o_lan_wake_request_in, .o_lan_subsystem_reset_in,
		.o_narrowband_subsystem_reset_in, .o_audio_rx_data, .o_audio_bit_clk_in,
		.o_audio_frame_sync_in, .o_low_energy_audio_sync, .o_link_reset_n, .o_link_wake_n_in,
		.o_link_clock_request_n_in, .o_gpio_in);
	gpfm_pad_world u_pads (.i_sys_clk, .i_oe(o_pad_oe), .i_out(o_pad_out), .i_pu(o_pad_pu),
		.i_pd(o_pad_pd), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(i_pad_in));
	task chk(input [15:0] got, input [15:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tick(input integer n);
		begin
			repeat (n) @(posedge i_sys_clk);
			#2;
		end
	endtask
	task test_done;
		begin
			if (err_count == 0 && cmp_count > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// Clock and watchdog
	initial forever #12.5 i_sys_clk = ~i_sys_clk;
	initial begin
		repeat (3000) @(posedge i_sys_clk);
		err_count = err_count + 1;
		test_done;
	end
	// Main sequence
	initial begin
		tick(8);
		chk(o_pad_oe, 16'h0001); // Reset pads
		chk(o_pad_pu, 16'h1ffe); // Pulls
		chk(o_fe_oe ^ o_fe_out, 16'hffff); // Front end
		chk({o_link_clock_request_n_oe, o_link_clock_request_n_out, o_link_wake_n_oe},
			16'h0004);
		chk(o_link_reset_pd, 16'h0001); // Pull-down
		i_rst_n = 1;
		i_func_sel = 39'h12_4924_9249;
		i_gpio_oe = 13'h1fff;
		i_front_end_ctrl_line = 16'hffff;
		tick(2);
		i_boot_done = 1;
		tick(1);
		i_boot_done = 0;
		tick(2);
		chk({o_pad_out[2:0], o_pad_oe}, 16'h2001); // Post boot
		chk(o_fe_out, 16'h0000); // Still low
		i_fw_dl_start = 1;
		tick(1);
		i_fw_dl_start = 0;
		{i_coex_serial_tx, i_narrowband_wake_to_host, i_lan_wake_to_host} = 3'h7;
		{i_narrowband_activity_lamp, i_lan_activity_lamp, i_audio_tx_data} = 3'h7;
		{i_audio_bit_clk, i_audio_frame_sync, i_stereo_codec_clock, i_ext_oscillator_enable} = 4'hf;
		{i_audio_central, i_pu_en, i_pd_en, ext_en, ext_val} = {1'b1, 13'h0, {3{13'h1fff}}};
		tick(4);
		chk(o_pad_oe, 16'h06bd); // Alt outputs
		chk(o_pad_out & o_pad_oe, 16'h06bd); // Sources
		chk(o_pad_pd, 16'h1942); // Input pulls
		chk({o_coex_priority_in, o_coex_request_in, o_lan_wake_request_in, o_audio_rx_data,
			o_narrowband_subsystem_reset_in}, 16'h001f);
		ext_val = 13'h0fff;
		for (c = 2; c < 4; c = c + 1) begin
			i_func_sel[38:33] = {c[2:0], c[2:0]};
			tick(2);
			chk({o_pad_oe[11], o_pad_out[11]}, c == 2 ? 16'h0003 : 16'h0002);
			chk(c == 2 ? o_coex_serial_rx : o_debug_serial_rx, 16'h0000);
		end
		i_audio_central = 0;
		ext_val = 13'h0ffb;
		i_func_sel[23:21] = 3'h2;
		i_func_sel[11:9] = 3'h2;
		tick(2);
		chk({o_pad_oe[4:2], o_pad_oe[7]}, 16'h0004); // Peripheral
		chk({o_audio_bit_clk_in, o_audio_frame_sync_in, o_lan_subsystem_reset_in},
			16'h0005);
		i_func_sel[8:6] = 3'h2;
		{ext_val[2], i_pad29_in} = 2'b10;
		tick(2);
		chk({o_pad_oe[2], o_low_energy_audio_sync}, 16'h0001); // Sync on pin 2
		i_le_sync_on_29 = 1;
		tick(2);
		chk(o_low_energy_audio_sync, 16'h0000); // Sync on pin 29
		{i_func_sel, i_gpio_oe, i_gpio_out, ext_val} = {39'h0, 13'h1555, 13'h0f0f, 13'h0aaa};
		{i_front_end_ctrl_line, ext_en} = {16'h0f0f, ~13'h1555};
		tick(3);
		chk(o_pad_oe, 16'h1555); // Plain pins
		chk(o_pad_out & o_pad_oe, 16'h0505); // Plain drive
		chk(o_gpio_in, 16'h0faf); // Pad readback
		{i_power_down_state, i_pdn_oe, i_pdn_val, i_fe_pdn_val} = {1'b1, 13'h3, 13'h1, 16'h00f0};
		tick(2);
		chk({o_pad_out[2:0] & o_pad_oe[2:0], o_pad_oe}, 16'h2003);
		chk(o_fe_oe & o_fe_out, 16'h00f0); // Down lines
		i_power_down_state = 0;
		tick(2);
		chk(o_pad_oe, 16'h1555); // Restored
		chk(o_fe_out, 16'h0f0f); // Restored
		{i_link_clock_request_n, i_link_wake_n, i_link_reset_n_pad} = 3'h0;
		tick(2);
		chk({o_link_clock_request_n_oe, o_link_clock_request_n_out, o_link_wake_n_oe,
			o_link_wake_n_out, o_link_reset_n}, 16'h0014);
		chk(o_link_clock_request_n_in, 16'h0000); // Request seen low
		{i_link_clock_request_n, i_link_wake_n, i_link_reset_n_pad, host_wake_n} = 4'he;
		tick(2);
		chk({o_link_clock_request_n_oe, o_link_wake_n_oe, o_link_wake_n_in, o_link_reset_n},
			16'h0001); // Host wake
		chk(o_link_clock_request_n_in, 16'h0001); // Host pull-up
		i_rst_n = 0;
		tick(1);
		i_rst_n = 1;
		tick(1);
		chk(o_fe_out, 16'h0000); // Second reset lines low
		chk(o_pad_oe, 16'h0001); // Second reset
		test_done;
	end
endmodule
